// file: hw/tpe_timer_pulse_unit_events.sv
// Purpose: event, flag, interrupt and trigger logic of a three-channel timer pulse unit
// Assumes: AHB-Lite word accesses; clock pins synchronous to sys_clk
// Notes: flags and requests lag the counter step by one and two cycles
// Function
// - quadrature mode four: B edges count, direction from A level, A edges ignored
// - compare, overflow and underflow sources, each with flag and enable
// - event sets its flag; request raised when enable also set
// - clearing the flag withdraws the request, no acknowledge
// - fixed order within channel: A,B,C,D, overflow, underflow; channel 0 first
// - eight compare requests: four on channel 0, two on channels 1 and 2
// - one overflow request per channel when flag and enable set
// - underflow requests only on channels 1 and 2
// - compare-A match with trigger enable sends converter start request
// - compare match produced in last state where count equals compare
// - on match drive the configured level onto the compare pin
// - no second match until the next counter clock event
// - overflow flag on up wrap, underflow flag on down wrap
// - channel 1 uses clock pins a,b; channel 2 uses pins c,d
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tpe_timer_pulse_unit_events (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    output logic [7:0] timer_capture_compare_pin,
    output logic [12:0] channel_requests,
    output logic [3:0] irq_source_id,
    output logic irq,
    output logic adc_start_request
);
    // ************************************************
    // bus front end
    // ************************************************
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] ctrl_q;
    logic [23:0] enable_q;
    logic [15:0] pinio_q;
    logic [23:0] flags_q;
    logic [23:0] flags_d;
    logic [23:0] seen_q;
    logic [23:0] seen_d;
    logic [2:0] dir_q;
    logic [7:0] div_cnt_q;
    logic int_tick_q;
    logic [1:0] b_prev_q;
    localparam int SRC_W = tpe_pkg::SRC_N;

    logic [31:0] rd_data;
    logic [SRC_W-1:0] src;
    logic [3:0] src_id;

    // hsize is not decoded: only whole-word transfers are supported
    wire addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
    wire take = hsel && htrans[1] && hready;
    wire rd_take = take && !hwrite;
    wire [7:0] a8 = haddr[7:0];
    wire wr_ctrl = wr_pend_q && (wr_addr_q == tpe_pkg::OFS_CTRL);
    wire wr_stat = wr_pend_q && (wr_addr_q == tpe_pkg::OFS_STATUS);
    wire wr_en = wr_pend_q && (wr_addr_q == tpe_pkg::OFS_ENABLE);
    wire wr_pin = wr_pend_q && (wr_addr_q == tpe_pkg::OFS_PINIO);
    wire rd_stat = rd_take && addr_ok && (a8 == tpe_pkg::OFS_STATUS);

    // ************************************************
    // channel clocks
    // ************************************************
    wire [7:0] div_val = ctrl_q[tpe_pkg::CTRL_DIV_LSB +: tpe_pkg::CTRL_DIV_W];
    wire [2:0] run = ctrl_q[tpe_pkg::CTRL_RUN_LSB +: tpe_pkg::CH_N];
    wire [1:0] quad = {ctrl_q[tpe_pkg::CTRL_QUAD2], ctrl_q[tpe_pkg::CTRL_QUAD1]};
    wire [1:0] ph_a = {ext_clock_in_c, ext_clock_in_a};
    wire [1:0] ph_b = {ext_clock_in_d, ext_clock_in_b};
    wire [1:0] q_step = ph_b ^ b_prev_q;
    // rise with a high or fall with a low counts up, i.e. a equals new b
    wire [1:0] q_up = ~(ph_a ^ ph_b);
    wire [2:0] tick = run & {quad[1] ? q_step[1] : int_tick_q,
                             quad[0] ? q_step[0] : int_tick_q,
                             int_tick_q};
    wire [2:0] up = {quad[1] ? q_up[1] : 1'b1, quad[0] ? q_up[0] : 1'b1, 1'b1};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 8'h00;
            int_tick_q <= 1'b0;
            b_prev_q <= 2'b00;
        end else begin
            div_cnt_q <= (div_cnt_q >= div_val) ? 8'h00 : div_cnt_q + 8'h01;
            int_tick_q <= (div_cnt_q >= div_val);
            b_prev_q <= ph_b;
        end
    end

    // ************************************************
    // channels
    // ************************************************
    logic [15:0] cnt_all [tpe_pkg::CH_N];
    logic [3:0][15:0] cmp_all [tpe_pkg::CH_N];
    tpe_pkg::tpe_ev_s ev [tpe_pkg::CH_N];
    logic [23:0] set_vec;
    logic [2:0] trig;

    genvar c;
    generate
        for (c = 0; c < tpe_pkg::CH_N; c++) begin : g_ch
            localparam logic [7:0] CNT_OFS = tpe_pkg::OFS_COUNT0 + 8'(4 * c);
            localparam logic [7:0] CMP_OFS = tpe_pkg::OFS_CMP0 + 8'(16 * c);
            tpe_pkg::tpe_wr_s wr;
            // one driver for the whole carrier
            wire [3:0] cmp_we_w = {wr_pend_q && (wr_addr_q == CMP_OFS + 8'h0C),
                                   wr_pend_q && (wr_addr_q == CMP_OFS + 8'h08),
                                   wr_pend_q && (wr_addr_q == CMP_OFS + 8'h04),
                                   wr_pend_q && (wr_addr_q == CMP_OFS)};
            assign wr = {wr_pend_q && (wr_addr_q == CNT_OFS), cmp_we_w, hwdata[15:0]};
            tpe_chan #(
                .NCMP((c == 0) ? 4 : 2)
            ) u_chan (
                .sys_clk(sys_clk),
                .rst(rst),
                .tick(tick[c]),
                .up(up[c]),
                .wr(wr),
                .count_q(cnt_all[c]),
                .cmp_val(cmp_all[c]),
                .ev_q(ev[c])
            );
            assign set_vec[c*tpe_pkg::FLD_W +: tpe_pkg::FLD_W] =
                {2'b00, ev[c].unf, ev[c].ovf, ev[c].match};
            assign trig[c] = ev[c].match[0] && enable_q[c*tpe_pkg::FLD_W + tpe_pkg::BIT_TRG];
        end
    endgenerate

    // ************************************************
    // status flags
    // ************************************************
    // clear only after read
    wire [23:0] clr_vec = wr_stat ? (~hwdata[23:0] & seen_q) : 24'h000000;
    // clear withdraws request
    // a new event in the clearing cycle keeps the flag set
    assign flags_d = ((flags_q & ~clr_vec) | set_vec) & tpe_pkg::FLAG_MASK;
    assign seen_d = ((seen_q & ~clr_vec) | (rd_stat ? flags_q : 24'h000000)) & flags_d;

    // ************************************************
    // requests and priority
    // ************************************************
    // flag and enable per source
    wire [23:0] act = flags_q & enable_q & tpe_pkg::FLAG_MASK;
    assign src = {act[21:20], act[17:16], act[13:12], act[9:8], act[4:0]};

    always_comb begin
        src_id = tpe_pkg::NO_SOURCE;
        for (int i = SRC_W - 1; i >= 0; i--) begin
            if (src[i]) begin
                src_id = 4'(i);
            end
        end
    end

    // ************************************************
    // register file
    // ************************************************
    wire [7:0] dir_bits = {5'b00000, dir_q};
    wire [23:0] stat_rd = flags_q | {dir_bits[2], 7'h00, dir_bits[1], 7'h00, dir_bits[0], 7'h00};
    wire [7:0] cnt_idx = a8 - tpe_pkg::OFS_COUNT0;
    wire [7:0] cmp_idx = a8 - tpe_pkg::OFS_CMP0;
    wire in_cnt = (a8 >= tpe_pkg::OFS_COUNT0) && (a8 <= tpe_pkg::OFS_COUNT2);
    wire in_cmp = (a8 >= tpe_pkg::OFS_CMP0) && (a8 <= tpe_pkg::OFS_CMP_LAST);
    wire [15:0] cnt_rd = cnt_all[cnt_idx[3:2]];
    wire [15:0] cmp_rd = cmp_all[cmp_idx[5:4]][cmp_idx[3:2]];
    assign rd_data = !addr_ok ? 32'h00000000 :
                     (a8 == tpe_pkg::OFS_CTRL) ? ctrl_q :
                     (a8 == tpe_pkg::OFS_STATUS) ? {8'h00, stat_rd} :
                     (a8 == tpe_pkg::OFS_ENABLE) ? {8'h00, enable_q} :
                     (a8 == tpe_pkg::OFS_PINIO) ? {16'h0000, pinio_q} :
                     in_cnt ? {16'h0000, cnt_rd} :
                     in_cmp ? {16'h0000, cmp_rd} : 32'h00000000;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite && addr_ok;
            wr_addr_q <= a8;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_data;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= tpe_pkg::CTRL_RST;
            enable_q <= tpe_pkg::ENABLE_RST;
            pinio_q <= tpe_pkg::PINIO_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {16'h0000, hwdata[15:8], 3'b000, hwdata[4:0]};
            end
            if (wr_en) begin
                enable_q <= hwdata[23:0] & tpe_pkg::ENABLE_MASK;
            end
            if (wr_pin) begin
                pinio_q <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q <= 24'h000000;
            seen_q <= 24'h000000;
            dir_q <= 3'b000;
            channel_requests <= 13'h0000;
            irq_source_id <= tpe_pkg::NO_SOURCE;
            irq <= 1'b0;
            adc_start_request <= 1'b0;
        end else begin
            flags_q <= flags_d;
            seen_q <= seen_d;
            // direction remembers the last counted step
            dir_q <= (tick & ~up) | (~tick & dir_q);
            channel_requests <= src;
            irq_source_id <= src_id;
            irq <= |src;
            adc_start_request <= |trig;
        end
    end

    // ************************************************
    // compare output pins
    // ************************************************
    genvar p;
    generate
        for (p = 0; p < tpe_pkg::PIN_N; p++) begin : g_pin
            localparam int PC = (p < 4) ? 0 : ((p < 6) ? 1 : 2);
            localparam int PK = (p < 4) ? p : ((p - 4) % 2);
            wire [1:0] act_code = pinio_q[2*p +: 2];
            wire hit = ev[PC].match[PK];
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    timer_capture_compare_pin[p] <= tpe_pkg::PIN_RST[p];
                end else if (hit) begin
                    case (act_code)
                        tpe_pkg::PIN_LOW: timer_capture_compare_pin[p] <= 1'b0;
                        tpe_pkg::PIN_HIGH: timer_capture_compare_pin[p] <= 1'b1;
                        tpe_pkg::PIN_TOGGLE: timer_capture_compare_pin[p] <= ~timer_capture_compare_pin[p];
                        default: timer_capture_compare_pin[p] <= timer_capture_compare_pin[p];
                    endcase
                end
            end
        end
    endgenerate
endmodule : tpe_timer_pulse_unit_events
`default_nettype wire

// file: hw/tpe_pkg.sv
// Purpose: shared constants and carriers of the timer pulse unit event block
// Assumes: 32-bit AHB-Lite word registers, three channels of 16-bit counters
// Notes: per-channel fields are eight bits wide inside the flag and enable words
package tpe_pkg;
    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ENABLE = 8'h08;
    localparam logic [7:0] OFS_PINIO = 8'h0C;
    localparam logic [7:0] OFS_COUNT0 = 8'h10;
    localparam logic [7:0] OFS_COUNT2 = 8'h18;
    localparam logic [7:0] OFS_CMP0 = 8'h20;
    localparam logic [7:0] OFS_CMP_LAST = 8'h4C;

    // ************************************************
    // sizes and field positions
    // ************************************************
    localparam int CH_N = 3;
    localparam int CMP_N = 4;
    localparam int FLD_W = 8;
    localparam int SRC_N = 13;
    localparam int PIN_N = 8;
    localparam int BIT_OVF = 4;
    localparam int BIT_UNF = 5;
    localparam int BIT_TRG = 6;
    localparam int BIT_DIR = 7;
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_QUAD1 = 3;
    localparam int CTRL_QUAD2 = 4;
    localparam int CTRL_DIV_LSB = 8;
    localparam int CTRL_DIV_W = 8;

    // ************************************************
    // implemented bits and reset values
    // ************************************************
    localparam logic [23:0] FLAG_MASK = 24'h33331F;
    localparam logic [23:0] ENABLE_MASK = 24'h73735F;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [23:0] ENABLE_RST = 24'h000000;
    localparam logic [15:0] PINIO_RST = 16'h0000;
    localparam logic [7:0] PIN_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'hFFFF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [3:0] NO_SOURCE = 4'hF;

    // ************************************************
    // pin action codes
    // ************************************************
    localparam logic [1:0] PIN_HOLD = 2'h0;
    localparam logic [1:0] PIN_LOW = 2'h1;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [1:0] PIN_TOGGLE = 2'h3;

    typedef struct packed {
        logic cnt_we;
        logic [3:0] cmp_we;
        logic [15:0] wdata;
    } tpe_wr_s;

    typedef struct packed {
        logic [3:0] match;
        logic ovf;
        logic unf;
    } tpe_ev_s;
endpackage : tpe_pkg

// file: hw/tpe_chan.sv
// Purpose: one 16-bit counter with its compare registers and event pulses
// Assumes: tick is a one-cycle count enable, up gives its direction
// Notes: compare slots above NCMP read as zero and never match
`timescale 1ns/100ps
`default_nettype none
module tpe_chan #(
    parameter int NCMP = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic up,
    input wire tpe_pkg::tpe_wr_s wr,
    output logic [15:0] count_q,
    output logic [3:0][15:0] cmp_val,
    output tpe_pkg::tpe_ev_s ev_q
);
    logic [15:0] count_d;
    logic [3:0] match;
    wire at_max = (count_q == tpe_pkg::COUNT_MAX);
    wire at_min = (count_q == tpe_pkg::COUNT_RST);

    // ************************************************
    // compare registers
    // ************************************************
    genvar k;
    generate
        for (k = 0; k < tpe_pkg::CMP_N; k++) begin : g_cmp
            if (k < NCMP) begin : g_on
                logic [15:0] cmp_q;
                always_ff @(posedge sys_clk or posedge rst) begin
                    if (rst) begin
                        cmp_q <= tpe_pkg::CMP_RST;
                    end else if (wr.cmp_we[k]) begin
                        cmp_q <= wr.wdata;
                    end
                end
                assign cmp_val[k] = cmp_q;
                // one per tick
                // a write to the register inhibits its match in that cycle
                assign match[k] = tick && (count_q == cmp_q) && !wr.cmp_we[k];
            end else begin : g_off
                assign cmp_val[k] = 16'h0000;
                assign match[k] = 1'b0;
            end
        end
    endgenerate

    // ************************************************
    // counter
    // ************************************************
    // counter write beats a count step in the same cycle
    assign count_d = wr.cnt_we ? wr.wdata :
                     !tick ? count_q :
                     up ? count_q + 16'h0001 : count_q - 16'h0001;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_q <= tpe_pkg::COUNT_RST;
            ev_q <= '0;
        end else begin
            count_q <= count_d;
            ev_q.match <= match;
            ev_q.ovf <= tick && up && at_max && !wr.cnt_we;
            ev_q.unf <= tick && !up && at_min && !wr.cnt_we;
        end
    end
endmodule : tpe_chan
`default_nettype wire

// file: tb/tpe_adc_model.sv
// Purpose: converter side partner that counts conversions started by the timer
// Assumes: start request is a one-cycle pulse in the sys_clk domain
// Notes: accept_timer stands for the converter's own trigger selection
`timescale 1ns/100ps
`default_nettype none
module tpe_adc_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic start_req,
    input wire logic accept_timer,
    output logic [7:0] conv_count_q
);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            conv_count_q <= 8'h00;
        end else if (start_req && accept_timer) begin
            conv_count_q <= conv_count_q + 8'h01;
        end
    end
endmodule : tpe_adc_model
`default_nettype wire

// file: tb/tpe_events_props.sv
// Purpose: port-level checker of the timer pulse unit event block
// Assumes: single clock domain, reset async high
// Notes: request falls are tied to a bus write three edges earlier
`timescale 1ns/100ps
`default_nettype none
module tpe_events_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [12:0] channel_requests,
    input wire logic [3:0] irq_source_id,
    input wire logic irq,
    input wire logic adc_start_request
);
    wire logic taken = hsel & htrans[1] & hready;
    wire logic rd_taken = taken & ~hwrite;
    wire logic wr_taken = taken & hwrite;
    // lowest index wins, so scan from the top down
    function automatic logic [3:0] lowest(input logic [12:0] r);
        lowest = 4'hF;
        for (int i = 12; i >= 0; i--) begin
            if (r[i]) lowest = i[3:0];
        end
    endfunction : lowest
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_irq_is_or: assert property (irq == (|channel_requests))
        else $error("irq differs from or of requests");
    a_id_lowest_set: assert property (|channel_requests |-> irq_source_id == lowest(channel_requests))
        else $error("source id is not the highest priority request");
    a_idle_no_id: assert property (channel_requests == 13'h0000 |-> irq_source_id == 4'hF)
        else $error("source id set with no request");
    a_id_in_range: assert property (irq_source_id <= 4'hC || irq_source_id == 4'hF)
        else $error("source id names no source");
    a_drop_after_write: assert property ((|($past(channel_requests) & ~channel_requests)) |-> $past(wr_taken, 3))
        else $error("request dropped without a bus write");
    a_read_data_stands: assert property (!$past(rd_taken) |-> $stable(hrdata))
        else $error("read data changed without a read");
    a_unmapped_reads_zero: assert property (rd_taken && haddr[31:8] != 24'h000000 |=> hrdata == 32'h00000000)
        else $error("unmapped read returned data");
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or erred");
    c_irq_raised: cover property ($rose(irq));
    c_adc_pulse: cover property (adc_start_request);
    c_underflow_id: cover property (irq_source_id == 4'h8);
endmodule : tpe_events_checker
bind tpe_timer_pulse_unit_events tpe_events_checker tpe_events_checker_inst (.sys_clk(sys_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .channel_requests(channel_requests), .irq_source_id(irq_source_id),
    .irq(irq), .adc_start_request(adc_start_request));
`default_nettype wire

// file: tb/test_tpe_timer_pulse_unit_events.sv
// Purpose: self-checking bench of the timer pulse unit event block
// Assumes: zero-wait AHB-Lite slave, quadrature pins sampled each clock
// Notes: compare value, prescale and quadrature walks drawn from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_tpe_timer_pulse_unit_events;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [3:0] ext = 4'h0;
    logic accept_timer = 1'b1;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] pins;
    logic [12:0] channel_requests;
    logic [3:0] irq_source_id;
    logic irq;
    logic adc_start_request;
    logic [7:0] conv_count;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int seed = 38;
    logic [31:0] rd;
    logic [31:0] r;
    logic [15:0] cmp;
    logic [15:0] exp_cnt;
    logic last_down;
    localparam logic [31:0] RST_ADDR [6] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h20, 32'h100};
    localparam logic [31:0] RST_VAL [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0};

    always #12.5 sys_clk = ~sys_clk;

    tpe_timer_pulse_unit_events tpe_timer_pulse_unit_events_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_clock_in_a(ext[0]), .ext_clock_in_b(ext[1]),
        .ext_clock_in_c(ext[2]), .ext_clock_in_d(ext[3]), .timer_capture_compare_pin(pins),
        .channel_requests(channel_requests), .irq_source_id(irq_source_id), .irq(irq),
        .adc_start_request(adc_start_request));
    tpe_adc_model tpe_adc_model_inst (.sys_clk(sys_clk), .rst(rst), .start_req(adc_start_request),
        .accept_timer(accept_timer), .conv_count_q(conv_count));

    // ************************************************
    // bus, pin and reporting helpers
    // ************************************************
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic ahb_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb_xfer

    task automatic wait_req(input int idx, input int lim);
        int n;
        n = 0;
        while (channel_requests[idx] !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : wait_req

    function automatic logic [15:0] qnext(input logic [15:0] c, input logic a, input logic b);
        return (a == b) ? c + 16'h1 : c - 16'h1;
    endfunction : qnext

    // spacing of four clocks keeps phase overlap well above the minimum
    task automatic qstep(input int ch, input logic tog_b);
        int ia;
        logic a;
        logic b;
        ia = 2 * (ch - 1);
        a = ext[ia] ^ !tog_b;
        b = ext[ia + 1] ^ tog_b;
        if (tog_b) begin
            exp_cnt = qnext(exp_cnt, a, b);
            last_down = (a != b);
        end
        @(posedge sys_clk);
        ext[ia] <= a;
        ext[ia + 1] <= b;
        repeat (3) @(posedge sys_clk);
    endtask : qstep

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            ahb_xfer(1'b0, RST_ADDR[i], 32'h0);
            `CHK(rd, RST_VAL[i])
        end
        r = $random(seed);
        cmp = 16'h0008 + {11'h0, r[4:0]};
        ahb_xfer(1'b1, 32'h20, {16'h0, cmp});
        ahb_xfer(1'b1, 32'h0C, 32'h3);
        ahb_xfer(1'b1, 32'h08, 32'h41);
        ahb_xfer(1'b1, 32'h00, {23'h0, r[8], 8'h01});
        wait_req(0, 300);
        `CHK(channel_requests, 13'h0001)
        `CHK(irq_source_id, 4'h0)
        `CHK(pins[0], 1'b1)
        ahb_xfer(1'b1, 32'h00, 32'h0);
        `CHK(conv_count, 8'h01)
        ahb_xfer(1'b1, 32'h04, 32'h0);
        repeat (4) @(posedge sys_clk);
        `CHK(irq, 1'b1)
        ahb_xfer(1'b0, 32'h04, 32'h0);
        `CHK(rd, 32'h1)
        ahb_xfer(1'b1, 32'h04, 32'h0);
        repeat (4) @(posedge sys_clk);
        `CHK(irq, 1'b0)
        ahb_xfer(1'b1, 32'h08, 32'h10);
        ahb_xfer(1'b1, 32'h10, 32'hFFFD);
        ahb_xfer(1'b1, 32'h00, 32'h1);
        wait_req(4, 40);
        ahb_xfer(1'b1, 32'h00, 32'h0);
        `CHK(channel_requests, 13'h0010)
        `CHK(irq_source_id, 4'h4)
        accept_timer <= 1'b0;
        ahb_xfer(1'b1, 32'h08, 32'h00606010);
        for (int ch = 1; ch < 3; ch++) begin
            ahb_xfer(1'b1, 32'h10 + 4 * ch, 32'h0);
            ahb_xfer(1'b1, 32'h00, (ch == 1) ? 32'h0A : 32'h14);
            exp_cnt = 16'h0;
            qstep(ch, 1'b1);
            wait_req(4 * ch + 4, 20);
            `CHK(channel_requests[4 * ch + 4], 1'b1)
            `CHK(irq_source_id, 4'h4)
            for (int i = 0; i < 24; i++) begin
                r = $random(seed);
                qstep(ch, r[0]);
            end
            ahb_xfer(1'b0, 32'h10 + 4 * ch, 32'h0);
            `CHK(rd[15:0], exp_cnt)
            ahb_xfer(1'b0, 32'h04, 32'h0);
            `CHK(rd[8 * ch + 7], last_down)
        end
        ahb_xfer(1'b0, 32'h04, 32'h0);
        ahb_xfer(1'b1, 32'h04, ~32'h10);
        repeat (4) @(posedge sys_clk);
        `CHK(channel_requests, 13'h1100)
        `CHK(irq_source_id, 4'h8)
        `CHK(conv_count, 8'h01)
        wrap_up();
    end
endmodule : test_tpe_timer_pulse_unit_events
`default_nettype wire
